// >>> core/rfs_sweep_engine.sv
// Ramped shift-keying sweep engine: parallel register port, step accumulator,
// tuning word select and phase accumulator.
// Assumes pins synchronous to i_mclk; host pulses i_update after programming.
//
// Functional notes
// - Ramping only when the mode field equals 010.
// - Rate timer is a 20-bit down counter ticking once at zero.
// - A level change on the keying pin starts the rate timer.
// - Ticks are N+1 clocks apart, N from 1 to 2^20-1.
// - Each tick adds the step word to the step accumulator, or subtracts it when heading back to the origin.
// - Accumulator offsets low or high word toward selected end; feeds phase.
// - Timer stops at destination; output dwells while pin holds.
// - Early pin toggle reverses the ramp at same rate and step.
// - Triangle bit sweeps continuously, ignores pin, equal dwell everywhere.
// - Pin level at triangle rising edge picks the starting end.
// - New step and rate values apply to following steps mid-ramp.
// - Step clear gives one-clock pulses on each update while set.
// - Clear-all holds both accumulators at zero until released.
// - A 32-bit internal update counter times register changes.
// - In ramped mode without triangle, pin low selects low word, pin high selects high word.
// - Written values take effect only at an update event: host strobe or internal update counter tick.
`timescale 1ns/1ps
module rfs_sweep_engine
    import rfs_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [rfs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_update,
    input wire logic i_shift_key_pin,
    output logic [7:0] o_rdata,
    output logic [rfs_pkg::TW_W-1:0] o_tuning_word,
    output logic [rfs_pkg::TW_W-1:0] o_phase,
    output logic o_ramp_tick,
    output logic o_update_tick
);
    import rfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Byte helpers shared by all wide registers
    function automatic logic [TW_W-1:0] put_byte(input logic [TW_W-1:0] v,
                                                 input logic [5:0] lane,
                                                 input logic [7:0] b);
        logic [TW_W-1:0] r;
        r = v;
        r[lane*8 +: 8] = b;
        return r;
    endfunction : put_byte

    function automatic logic [7:0] get_byte(input logic [TW_W-1:0] v,
                                            input logic [5:0] lane);
        return v[lane*8 +: 8];
    endfunction : get_byte

    ////////////////////////////////////////////////////////////////////////////
    // Shadow (host written) and active (after update) registers
    logic [TW_W-1:0] sh_low_q, sh_high_q, sh_step_q;
    logic [TW_W-1:0] low_tuning_word_q, high_tuning_word_q, step_size_word_q;
    logic [RATE_W-1:0] sh_rate_q, step_rate_count_q;
    logic [UPD_W-1:0] sh_upd_q, upd_period_q;
    logic [7:0] sh_ctrl_q, sweep_control_q;

    wire hit_low = (i_addr >= ADR_LOW_TW_HI) && (i_addr <= ADR_LOW_TW_LO);
    wire hit_high = (i_addr >= ADR_HIGH_TW_HI) && (i_addr <= ADR_HIGH_TW_LO);
    wire hit_step = (i_addr >= ADR_STEP_HI) && (i_addr <= ADR_STEP_LO);
    wire hit_upd = (i_addr >= ADR_UPD_HI) && (i_addr <= ADR_UPD_LO);
    wire hit_rate = (i_addr >= ADR_RATE_HI) && (i_addr <= ADR_RATE_LO);
    wire hit_ctrl = (i_addr == ADR_CTRL);
    wire [5:0] lane_low = ADR_LOW_TW_LO - i_addr;
    wire [5:0] lane_high = ADR_HIGH_TW_LO - i_addr;
    wire [5:0] lane_step = ADR_STEP_LO - i_addr;
    wire [5:0] lane_upd = ADR_UPD_LO - i_addr;
    wire [5:0] lane_rate = ADR_RATE_LO - i_addr;
    wire [TW_W-1:0] upd_wide = {16'h0, sh_upd_q};
    wire [TW_W-1:0] rate_wide = {28'h0, sh_rate_q};
    wire [TW_W-1:0] upd_put = put_byte(upd_wide, lane_upd, i_wdata);
    wire [TW_W-1:0] rate_put = put_byte(rate_wide, lane_rate, i_wdata);

    // Update event: host strobe or internal update counter
    logic upd_cnt_tick_q;
    wire upd_evt = i_update || upd_cnt_tick_q;

    // Host writes land in shadows; the strobe moves them all at once
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sh_low_q <= TW_RST;
            sh_high_q <= TW_RST;
            sh_step_q <= TW_RST;
            sh_upd_q <= UPD_RST;
            sh_rate_q <= RATE_RST;
            sh_ctrl_q <= CTRL_RST;
        end else if (i_wr) begin
            if (hit_low) sh_low_q <= put_byte(sh_low_q, lane_low, i_wdata);
            if (hit_high) sh_high_q <= put_byte(sh_high_q, lane_high, i_wdata);
            if (hit_step) sh_step_q <= put_byte(sh_step_q, lane_step, i_wdata);
            if (hit_upd) sh_upd_q <= upd_put[UPD_W-1:0];
            if (hit_rate) sh_rate_q <= rate_put[RATE_W-1:0];
            if (hit_ctrl) sh_ctrl_q <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            low_tuning_word_q <= TW_RST;
            high_tuning_word_q <= TW_RST;
            step_size_word_q <= TW_RST;
            upd_period_q <= UPD_RST;
            step_rate_count_q <= RATE_RST;
            sweep_control_q <= CTRL_RST;
        end else if (upd_evt) begin
            low_tuning_word_q <= sh_low_q;
            high_tuning_word_q <= sh_high_q;
            step_size_word_q <= sh_step_q;
            upd_period_q <= sh_upd_q;
            step_rate_count_q <= sh_rate_q;
            sweep_control_q <= sh_ctrl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal 32-bit update counter, reloads from its period register
    logic [UPD_W-1:0] upd_cnt_q;
    wire upd_cnt_on = sweep_control_q[CTRL_AUTO_UPD];
    wire upd_cnt_zero = upd_cnt_on && (upd_cnt_q == '0);

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            upd_cnt_q <= UPD_RST;
            upd_cnt_tick_q <= 1'b0;
        end else begin
            upd_cnt_q <= (!upd_cnt_on || upd_cnt_zero) ? upd_period_q : upd_cnt_q - 1'b1;
            upd_cnt_tick_q <= upd_cnt_zero;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sweep state and decode
    logic [TW_W-1:0] acc_q;
    logic origin_q, tri_dir_q, run_q, key_q, tri_q, clr_pulse_q;
    logic [TW_W-1:0] tw_q, phase_q;
    logic tick;

    wire ramp_mode = (sweep_control_q[CTRL_MODE_LSB +: 3] == MODE_RAMPED);
    wire tri_on = sweep_control_q[CTRL_TRIANGLE];
    wire clr_all = sweep_control_q[CTRL_CLR_ALL];
    wire key_edge = i_shift_key_pin != key_q;
    wire tri_rise = tri_on && !tri_q;
    // Triangle ignores the pin and follows its own direction flag
    wire target_hi = tri_on ? tri_dir_q : key_q;
    wire toward_far = target_hi != origin_q;
    wire [TW_W-1:0] span = high_tuning_word_q - low_tuning_word_q;
    wire [TW_W:0] acc_sum = {1'b0, acc_q} + {1'b0, step_size_word_q};
    // Clamp instead of overshooting either end
    wire [TW_W-1:0] acc_up = (acc_sum > {1'b0, span}) ? span : acc_sum[TW_W-1:0];
    wire [TW_W-1:0] acc_dn = (step_size_word_q > acc_q) ? '0 : acc_q - step_size_word_q;
    wire at_dest = toward_far ? (acc_q == span) : (acc_q == '0);
    wire timer_run = ramp_mode && !clr_all && (tri_on || (run_q && !at_dest));
    // A step clear restarts the timer so a ramp parked at its end sets off again
    wire timer_start = ramp_mode && (tri_rise || clr_pulse_q
                       || (key_edge && !tri_on));
    wire [TW_W-1:0] tw_d = clr_all ? '0 :
                           !ramp_mode ? low_tuning_word_q :
                           origin_q ? high_tuning_word_q - acc_q :
                           low_tuning_word_q + acc_q;

    rfs_rate_timer #(.W(RATE_W)) u_timer (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_run(timer_run),
        .i_start(timer_start),
        .i_rate(step_rate_count_q),
        .o_tick(tick)
    );

    // Accumulator and direction; clears win over stepping
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            acc_q <= TW_RST;
            origin_q <= 1'b0;
            tri_dir_q <= 1'b1;
            run_q <= 1'b0;
        end else begin
            if (clr_all || clr_pulse_q) begin
                acc_q <= '0;
                // Clear-all parks the sweep at the end that the pin selects
                if (clr_all) begin
                    origin_q <= key_q;
                end
            end else if (tri_rise) begin
                acc_q <= '0;
                origin_q <= key_q;
                tri_dir_q <= !key_q;
            end else if (tick && ramp_mode) begin
                // Reversal simply walks the same offset back down
                acc_q <= toward_far ? acc_up : acc_dn;
            end
            if (tri_on && ramp_mode && !tri_rise && at_dest) begin
                tri_dir_q <= !tri_dir_q;
            end
            if (key_edge && ramp_mode) begin
                run_q <= 1'b1;
            end else if (clr_pulse_q && ramp_mode) begin
                run_q <= 1'b1;
            end else if (at_dest) begin
                run_q <= 1'b0;
            end
        end
    end

    // Pin and edge history, one-clock step clear, output stages
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            key_q <= 1'b0;
            tri_q <= 1'b0;
            clr_pulse_q <= 1'b0;
            tw_q <= TW_RST;
            phase_q <= TW_RST;
        end else begin
            key_q <= i_shift_key_pin;
            tri_q <= tri_on;
            clr_pulse_q <= upd_evt && sh_ctrl_q[CTRL_CLR_STEP];
            tw_q <= tw_d;
            phase_q <= clr_all ? '0 : phase_q + tw_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: shadows read back, status shows live sweep state
    wire [7:0] status = {4'h0, run_q, at_dest, tri_dir_q, origin_q};
    wire [7:0] rd_mux = hit_low ? get_byte(sh_low_q, lane_low) :
                        hit_high ? get_byte(sh_high_q, lane_high) :
                        hit_step ? get_byte(sh_step_q, lane_step) :
                        hit_upd ? get_byte(upd_wide, lane_upd) :
                        hit_rate ? get_byte(rate_wide, lane_rate) :
                        hit_ctrl ? sh_ctrl_q :
                        (i_addr == ADR_STATUS) ? status : 8'h00;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end
    end

    assign o_tuning_word = tw_q;
    assign o_phase = phase_q;
    assign o_ramp_tick = tick;
    assign o_update_tick = upd_cnt_tick_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    a_mode_gate: assert property (!ramp_mode |-> !timer_run && !timer_start)
        else $error("rate timer active outside ramped mode");
    a_key_start: assert property (ramp_mode && key_edge && !tri_on |=> run_q)
        else $error("pin change did not start the ramp");
    a_dest_stop: assert property (!tri_on && at_dest && !key_edge && !clr_pulse_q
        |=> !run_q)
        else $error("timer kept running at destination");
    a_clear_restart: assert property (ramp_mode && clr_pulse_q |=> run_q)
        else $error("step clear did not restart the ramp");
    a_step_add: assert property (tick && ramp_mode && toward_far && !clr_all && !clr_pulse_q
        && !tri_rise && acc_sum <= {1'b0, span} |=> acc_q == $past(acc_sum[TW_W-1:0]))
        else $error("step word not accumulated");
    a_no_overshoot: assert property (tick && ramp_mode && toward_far && !tri_rise
        |=> acc_q <= $past(span))
        else $error("sweep passed destination");
    a_clear_all_hold: assert property (clr_all [*2] |=> tw_q == '0 && phase_q == '0)
        else $error("clear-all did not hold accumulators");
    a_clr_pulse_acc: assert property (clr_pulse_q |=> acc_q == '0)
        else $error("step clear pulse did not clear accumulator");
    a_tri_start: assert property (tri_rise && !clr_all && !clr_pulse_q
        |=> origin_q == $past(key_q) && acc_q == '0)
        else $error("triangle start point wrong");
    a_update_only: assert property (!upd_evt |=> $stable(step_size_word_q)
        && $stable(step_rate_count_q))
        else $error("active register changed without update");
    a_low_select: assert property (ramp_mode && !clr_all && !origin_q
        |=> tw_q == $past(low_tuning_word_q + acc_q))
        else $error("low word not selected");

    c_triangle: cover property (tri_on && ramp_mode && tick ##1 tri_dir_q != $past(tri_dir_q));
    c_dest: cover property (run_q ##1 !run_q);
    c_reverse: cover property (run_q && !at_dest && key_edge);
    c_clear: cover property (clr_pulse_q && acc_q != '0);
endmodule : rfs_sweep_engine

// >>> core/rfs_pkg.sv
// Constants for the ramped frequency-shift-keying sweep engine.
// Assumes byte-wide parallel programming, lowest address holds the most significant byte.
package rfs_pkg;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned TW_W = 48;
    localparam int unsigned RATE_W = 20;
    localparam int unsigned UPD_W = 32;
    // Byte ranges of the programming registers
    localparam logic [5:0] ADR_LOW_TW_HI = 6'h04;
    localparam logic [5:0] ADR_LOW_TW_LO = 6'h09;
    localparam logic [5:0] ADR_HIGH_TW_HI = 6'h0a;
    localparam logic [5:0] ADR_HIGH_TW_LO = 6'h0f;
    localparam logic [5:0] ADR_STEP_HI = 6'h10;
    localparam logic [5:0] ADR_STEP_LO = 6'h15;
    localparam logic [5:0] ADR_UPD_HI = 6'h16;
    localparam logic [5:0] ADR_UPD_LO = 6'h19;
    localparam logic [5:0] ADR_RATE_HI = 6'h1a;
    localparam logic [5:0] ADR_RATE_LO = 6'h1c;
    localparam logic [5:0] ADR_STATUS = 6'h1d;
    localparam logic [5:0] ADR_CTRL = 6'h1f;
    // sweep_control field positions
    localparam int unsigned CTRL_AUTO_UPD = 0;
    localparam int unsigned CTRL_MODE_LSB = 1;
    localparam int unsigned CTRL_TRIANGLE = 5;
    localparam int unsigned CTRL_CLR_ALL = 6;
    localparam int unsigned CTRL_CLR_STEP = 7;
    localparam logic [2:0] MODE_RAMPED = 3'h2;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [TW_W-1:0] TW_RST = 48'h0;
    localparam logic [RATE_W-1:0] RATE_RST = 20'h00001;
    localparam logic [UPD_W-1:0] UPD_RST = 32'h0;
endpackage : rfs_pkg

// >>> core/rfs_rate_timer.sv
// Ramp rate down counter: one-cycle tick every rate+1 clocks while running.
// Assumes the rate value is at least one and stable between ticks or reloads.
`timescale 1ns/1ps
module rfs_rate_timer #(
    parameter int unsigned W = 20
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_run,
    input wire logic i_start,
    input wire logic [W-1:0] i_rate,
    output logic o_tick
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic tick_d;

    // Reload on start and on every tick so new rates apply to the next step
    assign tick_d = i_run && !i_start && (count_q == '0);
    assign count_d = (i_start || tick_d) ? i_rate :
                     (i_run ? count_q - 1'b1 : count_q);

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_q <= '0;
            o_tick <= 1'b0;
        end else begin
            count_q <= count_d;
            o_tick <= tick_d;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    a_tick_single: assert property (o_tick && i_run && !i_start |=> !o_tick)
        else $error("rate tick lasted more than one cycle");
    a_tick_reload: assert property (o_tick |-> count_q == $past(i_rate))
        else $error("rate counter not reloaded on tick");
endmodule : rfs_rate_timer

// >>> dv/rfs_host_model.sv
// Host-side partner: drives the parallel byte port, update strobe and keying pin.
// Assumes the engine samples every input on the rising edge of i_mclk.
`timescale 1ns/1ps
module rfs_host_model (
    input wire logic i_mclk,
    output logic [5:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    output logic o_update,
    output logic o_key,
    input wire logic [7:0] i_rdata,
    input wire logic i_key_level
);
    // Keying pin follows the bench's level with no added delay
    assign o_key = i_key_level;

    // Idle levels at time zero
    initial begin
        o_addr = 6'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_update = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One byte write; idle data bus shows the inverse so stale data never matches
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask : wr

    // One byte read, answer taken the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_mclk);
        o_rd = 1'b0;
        d = i_rdata;
    endtask : rd

    // Multi-byte register, most significant byte at the lowest address
    task automatic put_word(input logic [5:0] a, input int n, input logic [47:0] v);
        for (int i = 0; i < n; i++) begin
            wr(a + 6'(i), v[8*(n-1-i) +: 8]);
        end
    endtask : put_word

    // Strobe issued only after all bytes are in
    task automatic pulse_update();
        @(negedge i_mclk);
        o_update = 1'b1;
        @(negedge i_mclk);
        o_update = 1'b0;
    endtask : pulse_update
endmodule : rfs_host_model

// >>> dv/rfs_sweep_engine_tb.sv
// Self-checking bench for the ramped shift-keying sweep engine.
// Assumes the host partner model in rfs_host_model.sv.
`timescale 1ns/1ps
module rfs_sweep_engine_tb;
    import rfs_pkg::*;
    typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;} rfs_row_t;
    localparam logic [47:0] LOW = 48'h1000;
    localparam logic [47:0] S = 48'h100;
    localparam logic [47:0] HIGH = 48'h1800;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, got;
    logic wr, rd, upd, key, ramp_tick, upd_tick;
    logic [47:0] tw, phase;
    int failures = 0, total_checks = 0, cyc = 0, last_t = 0, gap = 0, ticks = 0;
    int ulast = 0, ugap = 0, t0 = 0;
    bit watch = 0;
    logic key_level = 1'b0;
    logic [47:0] p0;
    // Readback rows: address, byte written, byte expected back
    rfs_row_t rows [5] = '{'{6'h10, 8'h12, 8'h12}, '{6'h15, 8'hab, 8'hab},
        '{6'h1a, 8'hff, 8'h0f}, '{6'h1c, 8'h55, 8'h55}, '{6'h3f, 8'haa, 8'h00}};

    // 40 MHz system clock
    always #12.5 mclk = ~mclk;

    rfs_sweep_engine rfs_sweep_engine_i (.i_mclk(mclk), .i_reset_n(reset_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_update(upd), .i_shift_key_pin(key),
        .o_rdata(rdata), .o_tuning_word(tw), .o_phase(phase), .o_ramp_tick(ramp_tick),
        .o_update_tick(upd_tick));
    rfs_host_model rfs_host_model_i (.i_mclk(mclk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd), .o_update(upd), .o_key(key), .i_rdata(rdata),
        .i_key_level(key_level));

    ////////////////////////////////////////////////////////////////////////////
    // Tick spacing and range watch, sampled mid-cycle where outputs are settled
    always @(negedge mclk) begin
        cyc++;
        if (ramp_tick === 1'b1) begin
            gap = cyc - last_t;
            last_t = cyc;
            ticks++;
        end
        if (upd_tick === 1'b1) begin
            ugap = cyc - ulast;
            ulast = cyc;
        end
        if (watch && (tw > HIGH || tw < LOW)) begin
            failures++;
            $display("Error tuning word range: expected %h..%h, seen %h", LOW, HIGH, tw);
        end
    end

    task automatic check(input string nm, input logic [47:0] e, input logic [47:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s: expected %h, seen %h", nm, e, g);
        end
    endtask : check

    // Bounded wait for a tuning word, then compare
    task automatic wait_tw(input string nm, input logic [47:0] e, input int n);
        int k = 0;
        while (tw !== e && k < n) begin
            @(negedge mclk);
            k++;
        end
        check(nm, e, tw);
    endtask : wait_tw

    task automatic set_ctrl(input logic [7:0] v);
        rfs_host_model_i.wr(ADR_CTRL, v);
        rfs_host_model_i.pulse_update();
    endtask : set_ctrl

    // Keying pin level, changed at the falling edge
    task automatic set_key(input logic k);
        @(negedge mclk);
        key_level = k;
    endtask : set_key

    task automatic conclude();
        $display("Checks made: %0d, mismatches: %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #500000;
        failures++;
        $display("Error watchdog: expected finish, seen hang");
        conclude();
    end

    // Main sequence
    initial begin
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        check("tuning word at reset", 48'h0, tw);
        rfs_host_model_i.rd(ADR_CTRL, got);
        check("control at reset", 48'h0, {40'h0, got});
        rfs_host_model_i.rd(ADR_RATE_LO, got);
        check("rate at reset", 48'h1, {40'h0, got});
        foreach (rows[i]) begin
            rfs_host_model_i.wr(rows[i].a, rows[i].d);
            rfs_host_model_i.rd(rows[i].a, got);
            check("readback", {40'h0, rows[i].e}, {40'h0, got});
        end
        // Program a ramp of eight steps, four cycles a step
        rfs_host_model_i.put_word(ADR_LOW_TW_HI, 6, LOW);
        rfs_host_model_i.put_word(ADR_HIGH_TW_HI, 6, HIGH);
        rfs_host_model_i.put_word(ADR_STEP_HI, 6, S);
        rfs_host_model_i.put_word(ADR_RATE_HI, 3, 48'd3);
        set_ctrl(8'h84);
        set_ctrl(8'h04);
        wait_tw("start at low word", LOW, 10);
        watch = 1;
        set_key(1'b1);
        wait_tw("ramp up to high word", HIGH, 80);
        check("tick spacing", 48'd4, 48'(gap));
        repeat (3) @(negedge mclk);
        t0 = ticks;
        repeat (20) @(negedge mclk);
        check("ticks while dwelling", 48'(t0), 48'(ticks));
        // Step clear sends the output back to its origin, then it ramps again
        set_ctrl(8'h84);
        wait_tw("step clear to origin", LOW, 6);
        set_ctrl(8'h04);
        wait_tw("ramp restarts after clear", HIGH, 80);
        // Rate change mid-ramp, then an early toggle reverses
        set_key(1'b0);
        wait_tw("first step down", HIGH - S, 20);
        rfs_host_model_i.wr(ADR_RATE_LO, 8'h01);
        rfs_host_model_i.pulse_update();
        wait_tw("fifth step down", HIGH - 5 * S, 40);
        check("new tick spacing", 48'd2, 48'(gap));
        set_key(1'b1);
        wait_tw("reversed back to high", HIGH, 40);
        set_key(1'b0);
        wait_tw("ramp down to low", LOW, 40);
        // Single-tone mode with the internal update counter, period 9
        rfs_host_model_i.put_word(ADR_UPD_HI, 4, 48'd9);
        set_ctrl(8'h01);
        t0 = ticks;
        set_key(1'b1);
        repeat (30) @(negedge mclk);
        check("no ramp outside mode", LOW, tw);
        check("no ticks outside mode", 48'(t0), 48'(ticks));
        check("update counter spacing", 48'd10, 48'(ugap));
        // Triangle armed with the pin high starts at the high word
        set_ctrl(8'h24);
        wait_tw("triangle start", HIGH, 8);
        set_key(1'b0);
        wait_tw("triangle down", LOW, 80);
        wait_tw("triangle up", HIGH, 80);
        // Clear-all holds both accumulators at zero until released
        watch = 0;
        set_ctrl(8'h44);
        repeat (4) @(negedge mclk);
        check("clear-all tuning word", 48'h0, tw);
        repeat (5) @(negedge mclk);
        check("clear-all phase", 48'h0, phase);
        set_ctrl(8'h04);
        wait_tw("resume after clear-all", LOW, 10);
        // Phase advances by the tuning word each clock
        p0 = phase;
        @(negedge mclk);
        check("phase step", LOW, phase - p0);
        // Mid-run reset brings outputs and control back to their reset state
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        check("tuning word after reset", 48'h0, tw);
        check("phase after reset", 48'h0, phase);
        rfs_host_model_i.rd(ADR_CTRL, got);
        check("control after reset", 48'h0, {40'h0, got});
        conclude();
    end
endmodule : rfs_sweep_engine_tb
